// ===== bench/uflc_remote.sv
// Remote serial party: paces the serializer and sources received characters
`timescale 1ns/1ps
module uflc_remote import uflc_pkg::*; (
    input  wire logic        pclk,
    input  wire uflc_txreq_t tx_req,
    output logic             tx_ready,
    output uflc_rx_t         rx_in
);
    logic [3:0] busy_ff = 4'h0;
    logic [8:0] sent_q[$];
    initial rx_in = '{valid: 1'h0, data: 8'h00};
    assign tx_ready = (busy_ff == 4'h0);
    ////////////////////////////////////////////////////////////////
    // Each character keeps the line busy for several cycles
    always @(posedge pclk) begin
        if (tx_req.start === 1'h1) begin
            busy_ff <= 4'h6;
            sent_q.push_back({tx_req.flow, tx_req.data});
        end else if (busy_ff != 4'h0) begin
            busy_ff <= busy_ff - 4'h1;
        end
    end
    task automatic send_char(input logic [7:0] ch);
        @(posedge pclk);
        rx_in <= '{valid: 1'h1, data: ch};
        @(posedge pclk);
        rx_in <= '{valid: 1'h0, data: ~ch}; // Stale data must never look valid
    endtask : send_char
endmodule : uflc_remote

// ===== bench/uflc_tb_top.sv
// Self-checking bench for the UART flow-control and reset block
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin fails++; \
    $display("CHECK FAILED %s exp %h got %h", nm, ex, got); end end
module uflc_tb_top import uflc_pkg::*; ;
    logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic        cts_n = 1'h0, tx_fifo_valid = 1'h0, tx_ready, pready, pslverr, err;
    logic        tx_fifo_pop, rx_store, int_out, sout_mark, rts_n, dtr_n;
    logic        rx_dma_ready_n, tx_dma_ready_n;
    logic [6:0]  paddr = 7'h00, rx_level = 7'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0]  modem_in = 4'ha;
    logic [7:0]  tx_fifo_data = 8'h5a;
    uflc_rx_t    rx_in;
    uflc_txreq_t tx_req;
    int          fails = 0, compares = 0, stores = 0, pops = 0;
    logic [6:0]  clr_a[6] = '{A_IEN, A_FCT, A_MCT, A_FEA, A_FTH, A_TRG};
    logic [6:0]  wr_a[7] = '{A_LCT, A_SCR, A_RES_A, A_RES_B, A_PAU_A, A_PAU_B, A_DVL};
    logic [7:0]  wr_d[7] = '{8'h03, 8'h3c, 8'h91, 8'h92, 8'h93, 8'h9a, 8'h27};
    logic [7:0]  mode[3] = '{8'h08, 8'h04, 8'h0c};
    int          nch[3] = '{1, 1, 2};
    logic [8:0]  ex_t[3][4] = '{'{9'h113, 9'h111, 9'h0, 9'h0}, '{9'h11a, 9'h112, 9'h0, 9'h0},
                                '{9'h113, 9'h11a, 9'h111, 9'h112}};
    uflc_top #(.FIFO_DEPTH(64), .THR_SCALE(4)) uflc_top_inst (.*);
    uflc_remote uflc_remote_inst (.*);
    always #10 pclk = ~pclk;
    always @(posedge pclk) if (rx_store === 1'h1) stores++;
    always @(posedge pclk) if (tx_fifo_pop === 1'h1) pops++;
    ////////////////////////////////////////////////////////////////
    task automatic apb(input logic wr, input logic [6:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1 && ++n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb
    task automatic chk_rd(input logic [6:0] a, input logic [7:0] ex, input string nm);
        apb(1'h0, a, 8'h00);
        `CHK(nm, {24'h0, ex}, rd)
    endtask : chk_rd
    task automatic wait_sent(input int want);
        for (int k = 0; k < 80 && uflc_remote_inst.sent_q.size() < want; k++) @(posedge pclk);
    endtask : wait_sent
    task automatic do_reset();
        presetn <= 1'h0;
        repeat (10) @(posedge pclk);
        `CHK("reset pins", 5'h1e, {sout_mark, rts_n, dtr_n, rx_dma_ready_n, tx_dma_ready_n})
        presetn <= 1'h1;
    endtask : do_reset
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : close_out
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge pclk);
        fails++;
        close_out();
    end
    initial begin
        do_reset();
        chk_rd(A_IID, IID_RST, "ident");
        chk_rd(A_LST, LST_RST, "line stat");
        chk_rd(A_MST, {modem_in, 4'h0}, "modem stat");
        foreach (clr_a[i]) chk_rd(clr_a[i], CLR8, "cleared reg");
        apb(1'h0, 7'h44, 8'h00);
        `CHK("unmapped", 33'h100000000, {err, rd})
        // Flow characters differ from the data byte 5a
        foreach (wr_a[i]) apb(1'h1, wr_a[i], wr_d[i]);
        do_reset();
        foreach (wr_a[i]) chk_rd(wr_a[i], i == 0 ? LCT_RST : wr_d[i], "kept reg");
        apb(1'h1, A_LCT, 8'h03);
        apb(1'h1, A_IEN, 8'h08);
        apb(1'h1, A_FEA, 8'h80); // Auto mode alone, no software flow
        cts_n <= 1'h1; // Dropped while the line is idle
        tx_fifo_valid <= 1'h1;
        repeat (20) @(posedge pclk);
        `CHK("held by cts", 0, uflc_remote_inst.sent_q.size())
        `CHK("cts irq in auto", 1'h0, int_out)
        cts_n <= 1'h0;
        wait_sent(1);
        `CHK("sent on cts", 9'h05a, uflc_remote_inst.sent_q[0])
        tx_fifo_valid <= 1'h0;
        apb(1'h1, A_FEA, 8'h00);
        uflc_remote_inst.sent_q.delete();
        cts_n <= 1'h1;
        tx_fifo_valid <= 1'h1;
        wait_sent(1);
        tx_fifo_valid <= 1'h0;
        `CHK("sent ignoring cts", 9'h05a, uflc_remote_inst.sent_q[0])
        `CHK("cts irq manual", 1'h1, int_out)
        apb(1'h1, A_IEN, 8'h20);
        apb(1'h1, A_FEA, 8'h02);
        uflc_remote_inst.sent_q.delete();
        uflc_remote_inst.send_char(8'h93);
        tx_fifo_valid <= 1'h1;
        repeat (20) @(posedge pclk);
        `CHK("halted", 0, uflc_remote_inst.sent_q.size())
        `CHK("pause irq", 1'h1, int_out)
        apb(1'h0, A_IID, 8'h00);
        `CHK("pause ident", 2'h2, {rd[IID_PAUSE], rd[IID_NOPEND]})
        uflc_remote_inst.send_char(8'h91);
        wait_sent(1);
        tx_fifo_valid <= 1'h0;
        `CHK("resumed", 9'h05a, uflc_remote_inst.sent_q[0])
        `CHK("resume irq", 1'h0, int_out)
        `CHK("flow chars stored", 0, stores)
        apb(1'h1, A_FEA, 8'h20);
        uflc_remote_inst.send_char(8'h9a);
        uflc_remote_inst.sent_q.delete();
        tx_fifo_valid <= 1'h1;
        wait_sent(1);
        tx_fifo_valid <= 1'h0;
        `CHK("special stored", 1, stores)
        `CHK("special no halt", 9'h05a, uflc_remote_inst.sent_q[0])
        `CHK("special irq", 1'h1, int_out)
        apb(1'h0, A_IID, 8'h00);
        `CHK("special ident", 1'h1, rd[IID_PAUSE])
        repeat (2) @(posedge pclk);
        `CHK("special cleared", 1'h0, int_out)
        apb(1'h1, A_MCT, 8'h20);
        apb(1'h1, A_FEA, 8'h02);
        uflc_remote_inst.send_char(8'h93);
        uflc_remote_inst.send_char(8'h55);
        uflc_remote_inst.sent_q.delete();
        tx_fifo_valid <= 1'h1;
        wait_sent(1);
        tx_fifo_valid <= 1'h0;
        `CHK("any resumed", 9'h05a, uflc_remote_inst.sent_q[0])
        `CHK("any stored", 2, stores)
        apb(1'h1, A_LCT, 8'h00);
        apb(1'h1, A_FTH, 8'h12);
        foreach (mode[i]) begin
            apb(1'h1, A_FEA, mode[i]);
            uflc_remote_inst.sent_q.delete();
            rx_level <= 7'h08;
            wait_sent(nch[i]);
            rx_level <= 7'h00;
            wait_sent(2 * nch[i]);
            `CHK("flow count", 2 * nch[i], uflc_remote_inst.sent_q.size())
            for (int j = 0; j < 2 * nch[i]; j++) begin
                `CHK("flow char", ex_t[i][j], uflc_remote_inst.sent_q[j])
            end
        end
        `CHK("data pops", 5, pops)
        close_out();
    end
endmodule : uflc_tb_top

// ===== hw/uflc_top.sv
// Flow control, register file and reset behaviour of one UART channel
//
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module uflc_top import uflc_pkg::*; #(
    parameter int FIFO_DEPTH = 64,
    parameter int THR_SCALE  = 4
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [REG_AW-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              cts_n,
    input  wire logic [3:0]        modem_in,
    input  wire uflc_rx_t          rx_in,
    input  wire logic [6:0]        rx_level,
    input  wire logic              tx_fifo_valid,
    input  wire logic [7:0]        tx_fifo_data,
    input  wire logic              tx_ready,
    output uflc_txreq_t            tx_req,
    output logic                   tx_fifo_pop,
    output logic                   rx_store,
    output logic                   int_out,
    output logic                   sout_mark,
    output logic                   rts_n,
    output logic                   dtr_n,
    output logic                   rx_dma_ready_n,
    output logic                   tx_dma_ready_n
);

    initial begin
        if (FIFO_DEPTH != 64 || THR_SCALE * 15 > FIFO_DEPTH)
            $error("uflc_top: unsupported FIFO_DEPTH or THR_SCALE");
    end

    function automatic logic [7:0] wl_mask(input logic [1:0] wl);
        case (wl)
            2'b00:   wl_mask = 8'h1f;
            2'b01:   wl_mask = 8'h3f;
            2'b10:   wl_mask = 8'h7f;
            default: wl_mask = 8'hff;
        endcase
    endfunction : wl_mask

    logic [7:0] ien_ff, fct_ff, lct_ff, mct_ff, fea_ff, fth_ff, trg_ff, lst_ff, mst_ff;
    logic [7:0] dvl_ff, dvh_ff, scr_ff, res_a_ff, res_b_ff, pau_a_ff, pau_b_ff;
    logic       mst_live_ff;
    logic [31:0]    prdata_ff;
    logic           pready_ff, pslverr_ff;
    logic           pause_flag_ff, halted_ff, seq_pause_ff, seq_res_ff;
    logic           remote_paused_ff, fc_kind_ff, cts_q_ff;
    uflc_fc_state_t fc_state_ff;
    uflc_txreq_t    tx_req_ff;
    logic           tx_pop_ff, rx_store_ff, int_ff, sout_mark_ff;
    logic           rts_n_ff, dtr_n_ff, rxdr_n_ff, txdr_n_ff;

    ////////////////////////////////////////////////////////////////////////////
    // APB slave: zero-wait access, one-cycle pready
    logic wr_acc, rd_acc, mapped;
    logic [7:0] rd_val;
    assign wr_acc = psel & penable & pready_ff & pwrite;
    assign rd_acc = psel & penable & pready_ff & ~pwrite;

    logic iid_pend;
    logic [7:0] iid_val;
    assign iid_pend = (pause_flag_ff & ien_ff[IEN_PAUSE])
                    | (|mst_ff[3:0] & ien_ff[IEN_MODEM]);
    always_comb begin
        iid_val = CLR8;
        iid_val[IID_NOPEND] = ~iid_pend;
        iid_val[IID_PAUSE]  = pause_flag_ff & ien_ff[IEN_PAUSE];
    end

    always_comb begin
        mapped = 1'b1;
        case (paddr)
            A_IEN:   rd_val = ien_ff;
            A_IID:   rd_val = iid_val;
            A_FCT:   rd_val = fct_ff;
            A_LCT:   rd_val = lct_ff;
            A_MCT:   rd_val = mct_ff;
            A_LST:   rd_val = lst_ff;
            A_MST:   rd_val = mst_ff;
            A_SCR:   rd_val = scr_ff;
            A_DVL:   rd_val = dvl_ff;
            A_DVH:   rd_val = dvh_ff;
            A_FEA:   rd_val = fea_ff;
            A_FTH:   rd_val = fth_ff;
            A_TRG:   rd_val = trg_ff;
            A_RES_A: rd_val = res_a_ff;
            A_RES_B: rd_val = res_b_ff;
            A_PAU_A: rd_val = pau_a_ff;
            A_PAU_B: rd_val = pau_b_ff;
            default: begin
                rd_val = CLR8;
                mapped = 1'b0;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end else begin
            pready_ff  <= psel & ~penable & ~pready_ff;
            pslverr_ff <= psel & ~penable & ~pready_ff & ~mapped;
            if (psel & ~penable & ~pwrite)
                prdata_ff <= {24'h00_0000, rd_val};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control registers: reset clears all but the line control, which loads LCT_RST
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ien_ff <= CLR8;
            fct_ff <= CLR8;
            mct_ff <= CLR8;
            fea_ff <= CLR8;
            fth_ff <= CLR8;
            trg_ff <= CLR8;
            lct_ff <= LCT_RST;
        end else if (wr_acc) begin
            case (paddr)
                A_IEN:   ien_ff <= pwdata[7:0];
                A_FCT:   fct_ff <= pwdata[7:0];
                A_LCT:   lct_ff <= pwdata[7:0];
                A_MCT:   mct_ff <= pwdata[7:0];
                A_FEA:   fea_ff <= pwdata[7:0];
                A_FTH:   fth_ff <= pwdata[7:0];
                A_TRG:   trg_ff <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    // No reset on purpose: survives the top-level reset
    always_ff @(posedge pclk) begin
        if (wr_acc) begin
            case (paddr)
                A_SCR:   scr_ff   <= pwdata[7:0];
                A_DVL:   dvl_ff   <= pwdata[7:0];
                A_DVH:   dvh_ff   <= pwdata[7:0];
                A_RES_A: res_a_ff <= pwdata[7:0];
                A_RES_B: res_b_ff <= pwdata[7:0];
                A_PAU_A: pau_a_ff <= pwdata[7:0];
                A_PAU_B: pau_b_ff <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Modem and line status
    logic auto_cts, cts_chg, mst_rd;
    assign auto_cts = fea_ff[FEA_AUTO_CTS];
    assign cts_chg  = cts_q_ff ^ cts_n;
    assign mst_rd   = rd_acc && paddr == A_MST;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cts_q_ff    <= 1'b1;
            mst_live_ff <= 1'b0;
            mst_ff      <= CLR8;
            lst_ff      <= LST_RST;
        end else begin
            cts_q_ff     <= cts_n;
            // First sample after reset only primes the history, no deltas
            mst_live_ff  <= 1'b1;
            mst_ff[7:4]  <= modem_in;
            // Auto mode gates the transmitter itself, so no change event
            mst_ff[MST_DCTS] <= (mst_live_ff & cts_chg & ~auto_cts)
                             | (mst_ff[MST_DCTS] & ~mst_rd);
            mst_ff[3:1]  <= ({3{mst_live_ff}} & (mst_ff[7:5] ^ modem_in[3:1]))
                          | (mst_ff[3:1] & {3{~mst_rd}});
            lst_ff[LST_THR_EMPTY] <= ~tx_fifo_valid;
            lst_ff[LST_TX_EMPTY]  <= ~tx_fifo_valid & tx_ready & ~tx_req_ff.start;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Receive-side flow character recognition
    logic [1:0] rx_sel, tx_sel;
    logic rxv, m_pa, m_pb, m_ra, m_rb, pause_det, resume_det, any_det, special_det;
    logic consumed, iid_rd;
    assign rx_sel = fea_ff[1:0];
    assign tx_sel = fea_ff[3:2];
    assign rxv    = rx_in.valid;
    assign m_pa   = rx_in.data == pau_a_ff;
    assign m_pb   = rx_in.data == pau_b_ff;
    assign m_ra   = rx_in.data == res_a_ff;
    assign m_rb   = rx_in.data == res_b_ff;
    assign iid_rd = rd_acc && paddr == A_IID;

    always_comb begin
        pause_det  = 1'b0;
        resume_det = 1'b0;
        case (rx_sel)
            SEL_FIRST: begin
                pause_det  = m_pa;
                resume_det = m_ra;
            end
            SEL_SECOND: begin
                pause_det  = m_pb;
                resume_det = m_rb;
            end
            SEL_BOTH: begin
                pause_det  = seq_pause_ff & m_pb;
                resume_det = seq_res_ff & m_rb;
            end
            default: ;
        endcase
        pause_det   = rxv & pause_det;
        any_det     = rxv & halted_ff & mct_ff[MCT_ANY] & ~pause_det;
        resume_det  = rxv & resume_det & ~any_det;
        special_det = rxv & fea_ff[FEA_SPECIAL] & m_pb & ~pause_det;
        // Leading sequence halves are consumed too; a resume used as any-resume
        // drops the pending sequence so its partner lands in the FIFO
        consumed = (rx_sel != SEL_NONE) & (pause_det | resume_det
                 | (rx_sel == SEL_BOTH & (m_pa | (m_ra & ~any_det))));
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seq_pause_ff  <= 1'b0;
            seq_res_ff    <= 1'b0;
            halted_ff     <= 1'b0;
            pause_flag_ff <= 1'b0;
            rx_store_ff   <= 1'b0;
        end else begin
            rx_store_ff <= rxv & ~consumed;
            if (rxv) begin
                seq_pause_ff <= m_pa;
                seq_res_ff   <= m_ra & ~any_det;
            end
            if (pause_det)
                halted_ff <= 1'b1;
            else if (resume_det | any_det)
                halted_ff <= 1'b0;
            // Set wins over both the resume and the ident read
            if (pause_det | special_det)
                pause_flag_ff <= 1'b1;
            else if (resume_det | any_det | (iid_rd & ien_ff[IEN_PAUSE]))
                pause_flag_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transmit-side flow characters and character start
    logic [6:0] halt_lvl, res_lvl;
    logic       want_pause, want_resume, slot, data_ok;
    logic [7:0] fc_char;
    uflc_fc_state_t nxt_fc_state;
    assign halt_lvl    = 7'(THR_SCALE * fth_ff[3:0]);
    assign res_lvl     = 7'(THR_SCALE * fth_ff[7:4]);
    assign want_pause  = tx_sel != SEL_NONE && !remote_paused_ff
                       && fth_ff[3:0] != 4'h0 && rx_level >= halt_lvl;
    assign want_resume = tx_sel != SEL_NONE && remote_paused_ff
                       && rx_level <= res_lvl;
    assign slot        = tx_ready & ~tx_req_ff.start;
    // Clear-to-send only matters in auto mode
    // A pause seen this cycle already blocks the next data start
    assign data_ok     = tx_fifo_valid & ~halted_ff & ~pause_det
                       & (~auto_cts | ~cts_n);

    always_comb begin
        case (tx_sel)
            SEL_SECOND: fc_char = fc_kind_ff ? res_b_ff : pau_b_ff;
            SEL_BOTH:   fc_char = (fc_state_ff == FC_SECOND)
                                ? (fc_kind_ff ? res_b_ff : pau_b_ff)
                                : (fc_kind_ff ? res_a_ff : pau_a_ff);
            default:    fc_char = fc_kind_ff ? res_a_ff : pau_a_ff;
        endcase
    end

    always_comb begin
        nxt_fc_state = fc_state_ff;
        case (fc_state_ff)
            FC_IDLE:   if (want_pause | want_resume) nxt_fc_state = FC_FIRST;
            FC_FIRST:  if (slot) nxt_fc_state = (tx_sel == SEL_BOTH) ? FC_SECOND : FC_IDLE;
            FC_SECOND: if (slot) nxt_fc_state = FC_IDLE;
            default:   nxt_fc_state = FC_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fc_state_ff      <= FC_IDLE;
            fc_kind_ff       <= 1'b0;
            remote_paused_ff <= 1'b0;
        end else begin
            fc_state_ff <= nxt_fc_state;
            if (fc_state_ff == FC_IDLE && (want_pause | want_resume)) begin
                fc_kind_ff       <= want_resume;
                remote_paused_ff <= want_pause;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_req_ff <= '0;
            tx_pop_ff <= 1'b0;
        end else begin
            tx_req_ff.start <= 1'b0;
            tx_req_ff.flow  <= 1'b0;
            tx_pop_ff       <= 1'b0;
            if (slot && fc_state_ff != FC_IDLE) begin
                // Flow characters bypass the pause halt and take precedence
                tx_req_ff.start <= 1'b1;
                tx_req_ff.flow  <= 1'b1;
                tx_req_ff.data  <= fc_char & wl_mask(lct_ff[1:0]);
            end else if (slot && data_ok && !tx_pop_ff) begin
                tx_req_ff.start <= 1'b1;
                tx_req_ff.data  <= tx_fifo_data & wl_mask(lct_ff[1:0]);
                tx_pop_ff       <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pins and interrupt line
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_ff       <= 1'b0;
            sout_mark_ff <= 1'b1;
            rts_n_ff     <= 1'b1;
            dtr_n_ff     <= 1'b1;
            rxdr_n_ff    <= 1'b1;
            txdr_n_ff    <= 1'b0;
        end else begin
            int_ff       <= iid_pend;
            sout_mark_ff <= 1'b0;
            rts_n_ff     <= ~mct_ff[1];
            dtr_n_ff     <= ~mct_ff[0];
            rxdr_n_ff    <= rx_level == 7'h00;
            txdr_n_ff    <= tx_fifo_valid;
        end
    end

    assign prdata         = prdata_ff;
    assign pready         = pready_ff;
    assign pslverr        = pslverr_ff;
    assign tx_req         = tx_req_ff;
    assign tx_fifo_pop    = tx_pop_ff;
    assign rx_store       = rx_store_ff;
    assign int_out        = int_ff;
    assign sout_mark      = sout_mark_ff;
    assign rts_n          = rts_n_ff;
    assign dtr_n          = dtr_n_ff;
    assign rx_dma_ready_n = rxdr_n_ff;
    assign tx_dma_ready_n = txdr_n_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    cts_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
        tx_req_ff.start && !tx_req_ff.flow && auto_cts |-> !$past(cts_n))
        else $error("data started with clear-to-send inactive");
    cts_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
        auto_cts && cts_chg && !mst_ff[MST_DCTS] |=> !mst_ff[MST_DCTS])
        else $error("clear-to-send change flagged in auto mode");
    halt_tx_a: assert property (@(posedge pclk) disable iff (!presetn)
        pause_det |=> !tx_req_ff.start || tx_req_ff.flow || $past(tx_req_ff.start))
        else $error("data started after pause");
    pause_int_a: assert property (@(posedge pclk) disable iff (!presetn)
        pause_det && ien_ff[IEN_PAUSE] |=> iid_val[IID_PAUSE] ##1 int_ff)
        else $error("pause did not raise ident bit and interrupt");
    resume_go_a: assert property (@(posedge pclk) disable iff (!presetn)
        (resume_det || any_det) && !pause_det |=> !halted_ff && !pause_flag_ff)
        else $error("resume did not clear halt and flag");
    special_a: assert property (@(posedge pclk) disable iff (!presetn)
        special_det && !halted_ff |=> rx_store_ff && pause_flag_ff && !halted_ff)
        else $error("special character mishandled");
    flow_send_a: assert property (@(posedge pclk) disable iff (!presetn)
        fc_state_ff == FC_FIRST && slot |=> tx_req_ff.start && tx_req_ff.flow)
        else $error("pending flow character not sent");
    word_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
        tx_req_ff.start |-> (tx_req_ff.data & ~wl_mask(lct_ff[1:0])) == 8'h00)
        else $error("bits above word length sent");

endmodule : uflc_top

// ===== inc/uflc_pkg.sv
// Constants, register map and carrier types for the UART flow-control and reset block
package uflc_pkg;

    localparam int          REG_AW        = 7;
    localparam logic [6:0]  A_IEN         = 7'h00;
    localparam logic [6:0]  A_IID         = 7'h04;
    localparam logic [6:0]  A_FCT         = 7'h08;
    localparam logic [6:0]  A_LCT         = 7'h0c;
    localparam logic [6:0]  A_MCT         = 7'h10;
    localparam logic [6:0]  A_LST         = 7'h14;
    localparam logic [6:0]  A_MST         = 7'h18;
    localparam logic [6:0]  A_SCR         = 7'h1c;
    localparam logic [6:0]  A_DVL         = 7'h20;
    localparam logic [6:0]  A_DVH         = 7'h24;
    localparam logic [6:0]  A_FEA         = 7'h28;
    localparam logic [6:0]  A_FTH         = 7'h2c;
    localparam logic [6:0]  A_TRG         = 7'h30;
    localparam logic [6:0]  A_RES_A       = 7'h34;
    localparam logic [6:0]  A_RES_B       = 7'h38;
    localparam logic [6:0]  A_PAU_A       = 7'h3c;
    localparam logic [6:0]  A_PAU_B       = 7'h40;

    localparam logic [7:0]  IID_RST       = 8'h01;
    localparam logic [7:0]  LCT_RST       = 8'h1d;
    localparam logic [7:0]  LST_RST       = 8'h60;
    localparam logic [7:0]  CLR8          = 8'h00;

    localparam int          IID_NOPEND    = 0;
    localparam int          IID_PAUSE     = 4;
    localparam int          IEN_MODEM     = 3;
    localparam int          IEN_PAUSE     = 5;
    localparam int          MCT_ANY       = 5;
    localparam int          FEA_SPECIAL   = 5;
    localparam int          FEA_AUTO_CTS  = 7;
    localparam int          LST_THR_EMPTY = 5;
    localparam int          LST_TX_EMPTY  = 6;
    localparam int          MST_DCTS      = 0;

    localparam logic [1:0]  SEL_NONE      = 2'b00;
    localparam logic [1:0]  SEL_SECOND    = 2'b01;
    localparam logic [1:0]  SEL_FIRST     = 2'b10;
    localparam logic [1:0]  SEL_BOTH      = 2'b11;

    typedef enum logic [1:0] {
        FC_IDLE   = 2'b00,
        FC_FIRST  = 2'b01,
        FC_SECOND = 2'b10
    } uflc_fc_state_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } uflc_rx_t;

    typedef struct packed {
        logic       start;
        logic       flow;
        logic [7:0] data;
    } uflc_txreq_t;

endpackage : uflc_pkg
